/* File: bench/auc_remote.sv */
// remote serial station: sends frames to the port and captures its output
`timescale 1ns/1ps
module auc_remote (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  initial line_out = 1'b1;
  // frame bits lsb first, then g bit times of idle high
  task automatic send(input logic [11:0] f, input int n, input int bt, input int g);
    for (int i = 0; i < n; i++) begin
      line_out = f[i];
      repeat (bt) @(negedge clk);
    end
    if (g > 0) begin
      line_out = 1'b1;
      repeat (g * bt) @(negedge clk);
    end
  endtask : send
  // waits for a start edge, then samples n bits at mid bit
  task automatic grab(input int n, input int bt, output logic [11:0] f);
    int w;
    w = 0;
    f = '1;
    while (line_in === 1'b1 && w < 9000) begin
      @(negedge clk);
      w++;
    end
    repeat (bt / 2) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      f[i] = line_in;
      repeat (bt) @(negedge clk);
    end
  endtask : grab
endmodule : auc_remote

/* File: bench/auc_top_tb_top.sv */
// self-checking bench for the serial port control block
`timescale 1ns/1ps
module auc_top_tb_top;
  import auc_pkg::*;
  logic clk, rst, cpu_wr, cpu_rd, port_pin_out, rx_line, irq_seen;
  logic serial_out_pin, rx_done_irq, tx_busy;
  logic [15:0] cpu_addr;
  logic [7:0] cpu_wdata, cpu_rdata, rd, m, d, st, bf;
  logic [1:0] b;
  logic [11:0] fe, fg, fx;
  int fail_count, n_checks, cyc, n;
  logic [33:0] rows [8] = '{{8'hc8, 8'ha5, 2'h0, 8'h00, 8'ha5},
    {8'hdc, 8'h3c, 2'h1, 8'h00, 8'h3c}, {8'he8, 8'h5a, 2'h0, 8'h00, 8'h5a},
    {8'hf8, 8'h01, 2'h1, 8'h04, 8'h01}, {8'hfa, 8'h81, 2'h1, 8'h04, 8'h81},
    {8'he4, 8'hff, 2'h0, 8'h00, 8'h7f}, {8'hc8, 8'h00, 2'h2, 8'h02, 8'h00},
    {8'hca, 8'h0f, 2'h2, 8'h02, 8'h0f}};
  auc_top dut_u (.clk(clk), .rst(rst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .serial_in_pin(rx_line), .port_pin_out(port_pin_out),
    .serial_out_pin(serial_out_pin), .rx_done_irq(rx_done_irq), .tx_busy(tx_busy));
  auc_remote rem_u (.clk(clk), .line_in(serial_out_pin), .line_out(rx_line));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %0t byte %h want %h", $time, g, e);
    end
  endtask : chk8
  task automatic chkf(input logic [11:0] g, input logic [11:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %0t frame %h want %h", $time, g, e);
    end
  endtask : chkf
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge clk);
    cpu_addr = a;
    cpu_wdata = v;
    cpu_wr = 1'b1;
    @(negedge clk);
    cpu_wr = 1'b0;
  endtask : wr
  task automatic rdr(input logic [15:0] a, output logic [7:0] v);
    @(negedge clk);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge clk);
    cpu_rd = 0;
    v = cpu_rdata;
  endtask : rdr
  // line bits of one frame for mode mm, data dd, fault ff; returns bit count
  function automatic int fr(input logic [7:0] mm, input logic [7:0] dd,
    input logic [1:0] ff, output logic [11:0] f);
    int k;
    logic [7:0] v;
    k = mm[MODE_CL] ? 8 : 7;
    v = dd & {mm[MODE_CL], 7'h7f};
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < k; i++) f[1 + i] = v[i];
    if (mm[5:4] != PAR_NONE) begin
      f[k + 1] = (mm[5:4] == PAR_ZERO) ? 1'b0 : (mm[5:4] == PAR_ODD) ? ~^v : ^v;
      f[k + 1] = f[k + 1] ^ (ff == 2'h1);
      k++;
    end
    f[k + 1] = (ff != 2'h2);
    return k + 2 + mm[MODE_SL];
  endfunction : fr
  task automatic rx(input logic [11:0] f, input int k, input int bt);
    irq_seen = 1'b0;
    fork
      rem_u.send(f, k, bt, 2);
      repeat ((k + 2) * bt) begin
        @(negedge clk);
        if (rx_done_irq === 1'b1) irq_seen = 1'b1;
      end
    join
  endtask : rx
  initial begin
    {rst, cpu_wr, cpu_rd, port_pin_out, cyc, fail_count, n_checks} = '0;
    rst = 1'b1;
    cpu_addr = 16'h0000;
    cpu_wdata = 8'h00;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    rdr(ADDR_MODE, rd); chk8(rd, 8'h00);
    rdr(ADDR_STAT, rd); chk8(rd, 8'h00);
    rdr(ADDR_BRG, rd); chk8(rd, 8'h00);
    rdr(ADDR_DATA, rd); chk8(rd, 8'hff);
    rdr(16'hffa3, rd); chk8(rd, 8'h00);
    port_pin_out = 1'b1;
    @(negedge clk); chk8({7'h0, serial_out_pin}, 8'h01);
    wr(ADDR_DATA, 8'h00);
    @(negedge clk); chk8({6'h0, tx_busy, serial_out_pin}, 8'h01);
    port_pin_out = 1'b0;
    wr(ADDR_BRG, 8'hff); rdr(ADDR_BRG, rd); chk8(rd, 8'h7f);
    wr(ADDR_STAT, 8'hff); rdr(ADDR_STAT, rd); chk8(rd, 8'h00);
    wr(ADDR_BRG, 8'h10);
    n = fr(8'hc8, 8'h5a, 2'h0, fx);
    rx(fx, n, 32); chk8({7'h0, irq_seen}, 8'h00);
    wr(ADDR_MODE, 8'hff); rdr(ADDR_MODE, rd); chk8(rd, 8'hfe);
    for (int r = 0; r < 8; r++) begin
      {m, d, b, st, bf} = rows[r];
      wr(ADDR_MODE, m);
      n = fr(m, d, b, fx);
      void'(fr(m, d, 2'h0, fe));
      wr(ADDR_DATA, d);
      fork
        rem_u.grab(n, 32, fg);
        rx(fx, n, 32);
      join
      chkf(fg, fe);
      chk8({7'h0, tx_busy}, 8'h00);
      chk8({7'h0, irq_seen}, {7'h0, st == 8'h00 || !m[MODE_ISRM]});
      rdr(ADDR_STAT, rd); chk8(rd, st);
      rdr(ADDR_DATA, rd); chk8(rd, bf);
    end
    wr(ADDR_MODE, 8'hcc);
    n = fr(8'hc8, 8'h11, 2'h0, fx);
    rem_u.send(fx, n, 32, 0);
    void'(fr(8'hc8, 8'h22, 2'h0, fx));
    rem_u.send(fx, n, 32, 2);
    rdr(ADDR_STAT, rd); chk8(rd, 8'h01);
    rem_u.send(fx, n, 32, 2);
    rdr(ADDR_STAT, rd); chk8(rd, 8'h01);
    rdr(ADDR_DATA, rd); chk8(rd, 8'h22);
    rem_u.send(fx, n, 32, 2);
    rdr(ADDR_STAT, rd); chk8(rd, 8'h00);
    wr(ADDR_MODE, 8'hc8);
    wr(ADDR_BRG, 8'h23);
    wr(ADDR_DATA, 8'h55);
    n = 0;
    while (tx_busy === 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk8({7'h0, n == 760}, 8'h01);
    void'(fr(8'hc8, 8'h96, 2'h0, fx));
    rx(fx, 10, 76); chk8({7'h0, irq_seen}, 8'h01);
    rdr(ADDR_DATA, rd); chk8(rd, 8'h96);
    complete_run();
  end
endmodule : auc_top_tb_top

/* File: hw/auc_baud.sv */
// bit rate generator: prescaler and 16+k divider with bit and mid-bit strobes
`timescale 1ns/1ps
module auc_baud
  import auc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic restart,
  input wire logic [2:0] presc_sel,
  input wire logic [3:0] div_sel,
  output logic bit_tick,
  output logic mid_tick
);
  logic [6:0] pre_q, pre_d, mask;
  logic [4:0] div_q, div_d, last, half;
  logic src;

  always_comb begin
    mask = 7'((8'h01 << presc_sel) - 8'h01);
    src = (pre_q & mask) == mask;
    last = DIV_BASE + 5'(div_sel) - 5'h01;
    half = 5'((6'(DIV_BASE) + 6'(div_sel)) >> 1);
    bit_tick = src && (div_q == last);
    mid_tick = src && (div_q == half);
    pre_d = restart ? 7'h00 : pre_q + 7'h01;
    div_d = div_q;
    if (restart) begin
      div_d = 5'h00;
    end else if (src) begin
      div_d = (div_q == last) ? 5'h00 : div_q + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pre_q <= 7'h00;
      div_q <= 5'h00;
    end else begin
      pre_q <= pre_d;
      div_q <= div_d;
    end
  end
endmodule : auc_baud

/* File: hw/auc_pkg.sv */
// constants for the asynchronous serial port control block
package auc_pkg;
  localparam logic [15:0] ADDR_MODE = 16'hffa0;
  localparam logic [15:0] ADDR_STAT = 16'hffa1;
  localparam logic [15:0] ADDR_BRG = 16'hffa2;
  localparam logic [15:0] ADDR_DATA = 16'hff18;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] BRG_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'hff;
  localparam logic [7:0] MODE_WMASK = 8'hfe;
  localparam logic [7:0] BRG_WMASK = 8'h7f;
  localparam int MODE_TXE = 7;
  localparam int MODE_RXE = 6;
  localparam int MODE_PS_HI = 5;
  localparam int MODE_PS_LO = 4;
  localparam int MODE_CL = 3;
  localparam int MODE_SL = 2;
  localparam int MODE_ISRM = 1;
  localparam int STAT_PE = 2;
  localparam int STAT_FE = 1;
  localparam int STAT_OVE = 0;
  localparam int BRG_PS_HI = 6;
  localparam int BRG_PS_LO = 4;
  localparam int BRG_DV_HI = 3;
  localparam int BRG_DV_LO = 0;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;
  localparam logic [4:0] DIV_BASE = 5'h10;
  localparam logic [2:0] LAST_BIT_7 = 3'h6;
  localparam logic [2:0] LAST_BIT_8 = 3'h7;
  typedef enum logic [4:0] {
    RX_IDLE = 5'b0_0001,
    RX_START = 5'b0_0010,
    RX_DATA = 5'b0_0100,
    RX_PAR = 5'b0_1000,
    RX_STOP = 5'b1_0000
  } auc_rx_e;
  typedef enum logic [5:0] {
    TX_IDLE = 6'b00_0001,
    TX_START = 6'b00_0010,
    TX_DATA = 6'b00_0100,
    TX_PAR = 6'b00_1000,
    TX_STOP1 = 6'b01_0000,
    TX_STOP2 = 6'b10_0000
  } auc_tx_e;
endpackage : auc_pkg

/* File: hw/auc_top.sv */
// asynchronous serial port: registers, transmitter, receiver and error flags
`timescale 1ns/1ps
// Operation
// - mode bit7 transmit, bit6 receive enables pins
// - parity codes none, zero, odd, even
// - zero-parity mode never flags parity error
// - stop length bit sends one or two
// - policy bit suppresses completion interrupt on error
// - read-only error status, resets to zero
// - parity mismatch sets parity error flag
// - missing stop bit sets framing error flag
// - only first stop bit is checked
// - reception into unread buffer sets overrun
// - overrun repeats until buffer is read
// - prescaler divides clock by two to n
// - divider divides source by sixteen plus k
// - divider register bit7 zero, resets zero
// - seven-bit characters read with zero msb
// - writing transmit data starts a framed transmission
module auc_top
  import auc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  input wire logic serial_in_pin,
  input wire logic port_pin_out,
  output logic serial_out_pin,
  output logic rx_done_irq,
  output logic tx_busy
);
  import auc_pkg::*;

  function automatic logic par_bit(input logic [7:0] d, input logic [1:0] ps);
    par_bit = (ps == PAR_ODD) ? ~(^d) : (ps == PAR_EVEN) ? (^d) : 1'b0;
  endfunction : par_bit

  logic [7:0] mode_q, mode_d, stat_q, stat_d, brg_q, brg_d, rxb_q, rxb_d, rdata_d;
  logic full_q, full_d;
  logic transmitter_enable, receiver_enable, char_length_sel, stop_length_sel;
  logic error_irq_policy;
  logic [1:0] par_sel;
  logic wr_mode, wr_brg, wr_data, rd_stat, rd_data;
  auc_rx_e rx_q, rx_d;
  auc_tx_e tx_q, tx_d;
  logic [7:0] rsh_q, rsh_d, rx_char, tsh_q, tsh_d;
  logic [2:0] rcnt_q, rcnt_d, tcnt_q, tcnt_d;
  logic rpar_q, rpar_d, rpe_q, rpe_d, tline_q, tline_d;
  logic rx_restart, rx_bit, rx_mid, tx_restart, tx_bit;
  logic rx_done, pe_set, fe_set, rx_err, tx_start;
  logic [2:0] last_bit;

  always_comb begin
    transmitter_enable = mode_q[MODE_TXE];
    receiver_enable = mode_q[MODE_RXE];
    par_sel = mode_q[MODE_PS_HI:MODE_PS_LO];
    char_length_sel = mode_q[MODE_CL];
    stop_length_sel = mode_q[MODE_SL];
    error_irq_policy = mode_q[MODE_ISRM];
    last_bit = char_length_sel ? LAST_BIT_8 : LAST_BIT_7;
    wr_mode = cpu_wr && (cpu_addr == ADDR_MODE);
    wr_brg = cpu_wr && (cpu_addr == ADDR_BRG);
    wr_data = cpu_wr && (cpu_addr == ADDR_DATA);
    rd_stat = cpu_rd && (cpu_addr == ADDR_STAT);
    rd_data = cpu_rd && (cpu_addr == ADDR_DATA);
  end

  auc_baud u_tx_baud (
    .clk(clk),
    .rst(rst),
    .restart(tx_restart),
    .presc_sel(brg_q[BRG_PS_HI:BRG_PS_LO]),
    .div_sel(brg_q[BRG_DV_HI:BRG_DV_LO]),
    .bit_tick(tx_bit),
    .mid_tick()
  );

  auc_baud u_rx_baud (
    .clk(clk),
    .rst(rst),
    .restart(rx_restart),
    .presc_sel(brg_q[BRG_PS_HI:BRG_PS_LO]),
    .div_sel(brg_q[BRG_DV_HI:BRG_DV_LO]),
    .bit_tick(rx_bit),
    .mid_tick(rx_mid)
  );

  // receiver
  always_comb begin
    rx_d = rx_q;
    rsh_d = rsh_q;
    rcnt_d = rcnt_q;
    rpar_d = rpar_q;
    rx_restart = 1'b0;
    rx_done = 1'b0;
    fe_set = 1'b0;
    rx_char = char_length_sel ? rsh_q : {1'b0, rsh_q[7:1]};
    pe_set = (par_sel[1] == 1'b1) && (rpar_q != par_bit(rx_char, par_sel));
    case (rx_q)
      RX_IDLE: begin
        if (receiver_enable && !serial_in_pin) begin
          rx_restart = 1'b1;
          rx_d = RX_START;
        end
      end
      RX_START: begin
        if (rx_mid) begin
          rx_d = serial_in_pin ? RX_IDLE : RX_DATA;
          rcnt_d = 3'h0;
        end
      end
      RX_DATA: begin
        if (rx_mid) begin
          rsh_d = {serial_in_pin, rsh_q[7:1]};
          rcnt_d = rcnt_q + 3'h1;
          if (rcnt_q == last_bit) begin
            rx_d = (par_sel == PAR_NONE) ? RX_STOP : RX_PAR;
          end
        end
      end
      RX_PAR: begin
        if (rx_mid) begin
          rpar_d = serial_in_pin;
          rx_d = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rx_mid) begin
          rx_done = 1'b1;
          fe_set = !serial_in_pin;
          rx_d = RX_IDLE;
        end
      end
      default: rx_d = RX_IDLE;
    endcase
    pe_set = pe_set && rx_done;
    rx_err = pe_set || fe_set || full_q;
    rx_done_irq = rx_done && !(rx_err && error_irq_policy);
  end

  // transmitter
  always_comb begin
    tx_d = tx_q;
    tsh_d = tsh_q;
    tcnt_d = tcnt_q;
    tline_d = tline_q;
    tx_start = wr_data && transmitter_enable && (tx_q == TX_IDLE);
    tx_restart = tx_start;
    case (tx_q)
      TX_IDLE: begin
        tline_d = 1'b1;
        if (tx_start) begin
          tsh_d = cpu_wdata & {char_length_sel, {7{1'b1}}};
          tcnt_d = 3'h0;
          tline_d = 1'b0;
          tx_d = TX_START;
        end
      end
      TX_START: begin
        if (tx_bit) begin
          tline_d = tsh_q[0];
          tx_d = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tx_bit) begin
          tcnt_d = tcnt_q + 3'h1;
          tline_d = tsh_q[tcnt_d];
          if (tcnt_q == last_bit) begin
            tline_d = (par_sel == PAR_NONE) ? 1'b1 : par_bit(tsh_q, par_sel);
            tx_d = (par_sel == PAR_NONE) ? TX_STOP1 : TX_PAR;
          end
        end
      end
      TX_PAR: begin
        if (tx_bit) begin
          tline_d = 1'b1;
          tx_d = TX_STOP1;
        end
      end
      TX_STOP1: begin
        if (tx_bit) begin
          tx_d = stop_length_sel ? TX_STOP2 : TX_IDLE;
        end
      end
      TX_STOP2: begin
        if (tx_bit) begin
          tx_d = TX_IDLE;
        end
      end
      default: tx_d = TX_IDLE;
    endcase
    tx_busy = (tx_q != TX_IDLE);
    serial_out_pin = transmitter_enable ? tline_q : port_pin_out;
  end

  // registers and flags
  always_comb begin
    mode_d = wr_mode ? (cpu_wdata & MODE_WMASK) : mode_q;
    brg_d = wr_brg ? (cpu_wdata & BRG_WMASK) : brg_q;
    stat_d = rd_stat ? STAT_RST : stat_q;
    full_d = rd_data ? 1'b0 : full_q;
    rxb_d = rxb_q;
    if (rx_done) begin
      rxb_d = rx_char;
      full_d = 1'b1;
      stat_d[STAT_PE] = stat_d[STAT_PE] | pe_set;
      stat_d[STAT_FE] = stat_d[STAT_FE] | fe_set;
      stat_d[STAT_OVE] = stat_d[STAT_OVE] | full_q;
    end
    case (cpu_addr)
      ADDR_MODE: rdata_d = mode_q;
      ADDR_STAT: rdata_d = stat_q;
      ADDR_BRG: rdata_d = brg_q;
      ADDR_DATA: rdata_d = rxb_q;
      default: rdata_d = 8'h00;
    endcase
    if (!cpu_rd) begin
      rdata_d = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= MODE_RST;
      stat_q <= STAT_RST;
      brg_q <= BRG_RST;
      rxb_q <= DATA_RST;
      full_q <= 1'b0;
      cpu_rdata <= 8'h00;
      rx_q <= RX_IDLE;
      rsh_q <= DATA_RST;
      rcnt_q <= 3'h0;
      rpar_q <= 1'b0;
      tx_q <= TX_IDLE;
      tsh_q <= DATA_RST;
      tcnt_q <= 3'h0;
      tline_q <= 1'b1;
    end else begin
      mode_q <= mode_d;
      stat_q <= stat_d;
      brg_q <= brg_d;
      rxb_q <= rxb_d;
      full_q <= full_d;
      cpu_rdata <= rdata_d;
      rx_q <= rx_d;
      rsh_q <= rsh_d;
      rcnt_q <= rcnt_d;
      rpar_q <= rpar_d;
      tx_q <= tx_d;
      tsh_q <= tsh_d;
      tcnt_q <= tcnt_d;
      tline_q <= tline_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_MODE_B0: assert property (mode_q[0] == 1'b0)
    else $error("mode bit0 not zero");
  AST_PORT_PIN: assert property (!transmitter_enable |-> serial_out_pin == port_pin_out)
    else $error("pin not in port function");
  AST_ZERO_PAR: assert property (rx_done && par_sel == PAR_ZERO |=> !stat_q[STAT_PE]
    || $past(stat_q[STAT_PE]))
    else $error("parity error in zero parity mode");
  AST_TWO_STOP: assert property (tx_q == TX_STOP1 && tx_bit && stop_length_sel
    |=> tx_q == TX_STOP2 && tline_q)
    else $error("second stop bit missing");
  AST_IRQ_MASK: assert property (rx_done && rx_err && error_irq_policy |-> !rx_done_irq)
    else $error("irq on error despite policy");
  AST_IRQ_CLEAN: assert property (rx_done && !rx_err |-> rx_done_irq)
    else $error("clean reception without irq");
  AST_STAT_HI: assert property (stat_q[7:3] == 5'h00)
    else $error("status upper bits set");
  AST_FRAMING: assert property (rx_q == RX_STOP && rx_mid && !serial_in_pin
    |=> stat_q[STAT_FE])
    else $error("framing error not flagged");
  AST_OVERRUN: assert property (rx_done && full_q |=> stat_q[STAT_OVE] && full_q)
    else $error("overrun not flagged");
  AST_BRG_B7: assert property (brg_q[7] == 1'b0)
    else $error("divider bit7 not zero");
  AST_RXB_MSB: assert property (rx_done && !char_length_sel |=> rxb_q[7] == 1'b0)
    else $error("seven-bit msb not zero");
  AST_TX_GO: assert property (tx_start |=> tx_q == TX_START && !tline_q [*2])
    else $error("transmission not started");

  COV_RX: cover property (rx_done && !rx_err);
  COV_OVR: cover property (rx_done && full_q);
  COV_TX2: cover property (tx_q == TX_STOP2 && tx_bit);
endmodule : auc_top
